// ---- host_model.sv ----
// host processor model that issues register reads on the status bank
`timescale 1ns/100ps
module host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i,
  output logic      [7:0] addr_o,
  output logic            rd_o
);
  initial begin
    addr_o = 8'h00;
    rd_o = 1'b0;
  end

  // one-cycle read strobe, answer taken when the valid pulse shows
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    int n;
    n = 0;
    @(negedge clk_i);
    addr_o = addr;
    rd_o = 1'b1;
    @(negedge clk_i);
    rd_o = 1'b0;
    // released address bus must not keep the old value
    addr_o = ~addr;
    while (rvalid_i !== 1'b1 && n < 4) begin
      @(negedge clk_i);
      n++;
    end
    data = (rvalid_i === 1'b1) ? rdata_i : 8'hxx;
  endtask
endmodule

// ---- line_status_consts.svh ----
// register offsets, bit positions, reset values and timing counts of the status bank
`ifndef LINE_STATUS_CONSTS_SVH
`define LINE_STATUS_CONSTS_SVH

`define OFS_LINE_STATUS_ONE       8'h18
`define OFS_EVENT_LATCH_ZERO      8'h19
`define OFS_EVENT_LATCH_ONE       8'h1a
`define OFS_ERROR_COUNT_LOW_BYTE  8'h1b
`define OFS_ERROR_COUNT_HIGH_BYTE 8'h1c

`define BIT_REMOTE_LOOPBACK_CLOSED 5

`define BIT_LOOP_ACTIVATE      6
`define BIT_LOOP_DEACTIVATE    5
`define BIT_PATTERN_SYNC       4
`define BIT_TX_CLOCK_LOSS      3
`define BIT_DRIVER_FAULT       2
`define BIT_ALARM_INDICATION   1
`define BIT_SIGNAL_ABSENCE     0

`define BIT_WAVEFORM_OVERFLOW  7
`define BIT_JITTER_OVERFLOW    6
`define BIT_JITTER_UNDERFLOW   5
`define BIT_PATTERN_BIT_ERROR  4
`define BIT_EXCESS_ZEROS       3
`define BIT_CODE_VIOLATION     2
`define BIT_ONE_SECOND_TICK    1
`define BIT_COUNTER_OVERFLOW   0

`define RST_EVENT_LATCH        8'h00
`define RST_ERROR_COUNT        16'h0000
`define RST_READ_DATA          8'h00
`define EVENT_ZERO_USED_BITS   8'h7f

`define TX_CLOCK_LOSS_CYCLES   70

`endif

// ---- line_status_pkg.sv ----
// shared types of the line status and event register bank
package line_status_pkg;
  typedef logic [7:0]  byte_t;
  typedef logic [15:0] event_vec_t;
  typedef logic [15:0] count_t;
endpackage

// ---- line_status_regs.sv ----
// line status, read-to-clear event and error counter registers with interrupt request
`timescale 1ns/100ps
`include "line_status_consts.svh"
module line_status_regs
  import line_status_pkg::*;
(
  input  wire logic        SYS_CLK_I,
  input  wire logic        RSTN_I,
  input  wire logic [7:0]  HOST_ADDR_I,
  input  wire logic        HOST_RD_I,
  output logic      [7:0]  HOST_RDATA_O,
  output logic             HOST_RVALID_O,
  output logic             INT_REQ_O,
  input  wire logic        REMOTE_LOOPBACK_CLOSED_I,
  input  wire logic        LOOP_ACTIVATE_STAT_I,
  input  wire logic        LOOP_DEACTIVATE_STAT_I,
  input  wire logic        PATTERN_SYNC_STAT_I,
  input  wire logic        TRANSMIT_CLOCK_IN_I,
  input  wire logic        DRIVER_FAULT_STAT_I,
  input  wire logic        ALARM_INDICATION_STAT_I,
  input  wire logic        SIGNAL_ABSENCE_STAT_I,
  input  wire logic        WAVEFORM_OVERFLOW_I,
  input  wire logic        JITTER_OVERFLOW_I,
  input  wire logic        JITTER_UNDERFLOW_I,
  input  wire logic        PATTERN_BIT_ERROR_I,
  input  wire logic        EXCESS_ZEROS_I,
  input  wire logic        CODE_VIOLATION_I,
  input  wire logic        ONE_SECOND_TICK_I,
  input  wire logic        ERROR_COUNT_INC_I,
  input  wire logic [15:0] EVENT_MASK_I,
  input  wire logic [15:0] EVENT_EDGE_SELECT_I
);

  localparam int          SYNC_W     = 14;
  localparam logic [6:0]  LOSS_LIMIT = 7'(`TX_CLOCK_LOSS_CYCLES);

  // two-stage synchronisers for pin-side levels; stage one feeds stage two only
  logic [SYNC_W-1:0] sync1_ff;
  logic [SYNC_W-1:0] sync2_ff;
  logic [SYNC_W-1:0] async_in;

  assign async_in = {REMOTE_LOOPBACK_CLOSED_I, TRANSMIT_CLOCK_IN_I,
                     CODE_VIOLATION_I, EXCESS_ZEROS_I, PATTERN_BIT_ERROR_I,
                     JITTER_UNDERFLOW_I, JITTER_OVERFLOW_I, WAVEFORM_OVERFLOW_I,
                     SIGNAL_ABSENCE_STAT_I, ALARM_INDICATION_STAT_I, DRIVER_FAULT_STAT_I,
                     PATTERN_SYNC_STAT_I, LOOP_DEACTIVATE_STAT_I, LOOP_ACTIVATE_STAT_I};

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= async_in;
      sync2_ff <= sync1_ff;
    end
  end

  wire logic rl_closed_s  = sync2_ff[13];
  wire logic transmit_clock_in_s       = sync2_ff[12];

  // transmit clock watchdog: counts quiet cycles, saturating one past the limit
  logic       transmit_clock_in_prev_ff;
  logic [6:0] idle_cnt_ff;
  logic [6:0] nxt_idle_cnt;
  logic       transmit_clock_in_loss_ff;
  wire  logic transmit_clock_in_toggled = transmit_clock_in_s ^ transmit_clock_in_prev_ff;
  wire  logic idle_sat     = (idle_cnt_ff > LOSS_LIMIT);

  assign nxt_idle_cnt = transmit_clock_in_toggled ? 7'h00 : (idle_sat ? idle_cnt_ff : idle_cnt_ff + 7'h01);

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      transmit_clock_in_prev_ff <= 1'b0;
      idle_cnt_ff  <= 7'h00;
      transmit_clock_in_loss_ff <= 1'b0;
    end else begin
      transmit_clock_in_prev_ff <= transmit_clock_in_s;
      idle_cnt_ff  <= nxt_idle_cnt;
      transmit_clock_in_loss_ff <= (nxt_idle_cnt > LOSS_LIMIT);
    end
  end

  // 16-bit error counter; wraps to zero and flags overflow
  count_t err_cnt_ff;
  logic   cnt_ovf_ff;
  wire logic cnt_full = (err_cnt_ff == 16'hffff);

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      err_cnt_ff <= `RST_ERROR_COUNT;
      cnt_ovf_ff <= 1'b0;
    end else begin
      if (ERROR_COUNT_INC_I) begin
        err_cnt_ff <= err_cnt_ff + 16'h0001;
      end
      cnt_ovf_ff <= ERROR_COUNT_INC_I & cnt_full;
    end
  end

  // event sources: low byte feeds event latch zero, high byte event latch one
  event_vec_t src;
  event_vec_t src_prev_ff;
  event_vec_t hit;

  assign src[7]                            = 1'b0;
  assign src[`BIT_LOOP_ACTIVATE]           = sync2_ff[0];
  assign src[`BIT_LOOP_DEACTIVATE]         = sync2_ff[1];
  assign src[`BIT_PATTERN_SYNC]            = sync2_ff[2];
  assign src[`BIT_TX_CLOCK_LOSS]           = transmit_clock_in_loss_ff;
  assign src[`BIT_DRIVER_FAULT]            = sync2_ff[3];
  assign src[`BIT_ALARM_INDICATION]        = sync2_ff[4];
  assign src[`BIT_SIGNAL_ABSENCE]          = sync2_ff[5];
  assign src[8+`BIT_WAVEFORM_OVERFLOW]     = sync2_ff[6];
  assign src[8+`BIT_JITTER_OVERFLOW]       = sync2_ff[7];
  assign src[8+`BIT_JITTER_UNDERFLOW]      = sync2_ff[8];
  assign src[8+`BIT_PATTERN_BIT_ERROR]     = sync2_ff[9];
  assign src[8+`BIT_EXCESS_ZEROS]          = sync2_ff[10];
  assign src[8+`BIT_CODE_VIOLATION]        = sync2_ff[11];
  assign src[8+`BIT_ONE_SECOND_TICK]       = ONE_SECOND_TICK_I;
  assign src[8+`BIT_COUNTER_OVERFLOW]      = cnt_ovf_ff;

  // mask high blocks; edge select picks rising edge or any change
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_detect
      assign hit[gi] = ~EVENT_MASK_I[gi] &
                       (EVENT_EDGE_SELECT_I[gi] ? (src[gi] ^ src_prev_ff[gi])
                                                : (src[gi] & ~src_prev_ff[gi]));
    end
  endgenerate

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      src_prev_ff <= '0;
    end else begin
      src_prev_ff <= src;
    end
  end

  // host read decode
  wire logic sel_status = (HOST_ADDR_I == `OFS_LINE_STATUS_ONE);
  wire logic sel_ev0    = (HOST_ADDR_I == `OFS_EVENT_LATCH_ZERO);
  wire logic sel_ev1    = (HOST_ADDR_I == `OFS_EVENT_LATCH_ONE);
  wire logic sel_cnt_lo = (HOST_ADDR_I == `OFS_ERROR_COUNT_LOW_BYTE);
  wire logic sel_cnt_hi = (HOST_ADDR_I == `OFS_ERROR_COUNT_HIGH_BYTE);
  wire logic clr_ev0    = HOST_RD_I & sel_ev0;
  wire logic clr_ev1    = HOST_RD_I & sel_ev1;

  // event latches: a set in the clearing cycle survives the clear
  byte_t ev0_ff;
  byte_t ev1_ff;
  byte_t nxt_ev0;
  byte_t nxt_ev1;

  assign nxt_ev0 = ((clr_ev0 ? 8'h00 : ev0_ff) | hit[7:0]) & `EVENT_ZERO_USED_BITS;
  assign nxt_ev1 =  (clr_ev1 ? 8'h00 : ev1_ff) | hit[15:8];

  byte_t status_byte;
  byte_t rd_mux;

  assign status_byte = 8'(rl_closed_s) << `BIT_REMOTE_LOOPBACK_CLOSED;
  assign rd_mux = sel_status ? status_byte :
                  sel_ev0    ? ev0_ff :
                  sel_ev1    ? ev1_ff :
                  sel_cnt_lo ? err_cnt_ff[7:0] :
                  sel_cnt_hi ? err_cnt_ff[15:8] :
                               8'h00;

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ev0_ff        <= `RST_EVENT_LATCH;
      ev1_ff        <= `RST_EVENT_LATCH;
      HOST_RDATA_O  <= `RST_READ_DATA;
      HOST_RVALID_O <= 1'b0;
      INT_REQ_O     <= 1'b0;
    end else begin
      ev0_ff        <= nxt_ev0;
      ev1_ff        <= nxt_ev1;
      HOST_RVALID_O <= HOST_RD_I;
      INT_REQ_O     <= |{nxt_ev0, nxt_ev1};
      if (HOST_RD_I) begin
        HOST_RDATA_O <= rd_mux;
      end
    end
  end

  // checks
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RSTN_I);

  sequence s_read_ev0;
    HOST_RD_I && (HOST_ADDR_I == `OFS_EVENT_LATCH_ZERO);
  endsequence

  sequence s_read_ev1;
    HOST_RD_I && (HOST_ADDR_I == `OFS_EVENT_LATCH_ONE);
  endsequence

  property p_remote_loop;
    HOST_RD_I && (HOST_ADDR_I == `OFS_LINE_STATUS_ONE) |=>
      HOST_RVALID_O && (HOST_RDATA_O == {2'b00, $past(rl_closed_s), 5'b00000});
  endproperty
  a_remote_loop: assert property (p_remote_loop) else $error("line status readback wrong");

  property p_ev0_clear;
    s_read_ev0 ##0 (hit[7:0] == 8'h00) |=> (ev0_ff == 8'h00) && (HOST_RDATA_O == $past(ev0_ff));
  endproperty
  a_ev0_clear: assert property (p_ev0_clear) else $error("event zero not returned then cleared");

  property p_ev1_clear;
    s_read_ev1 ##0 (hit[15:8] == 8'h00) |=> (ev1_ff == 8'h00) && (HOST_RDATA_O == $past(ev1_ff));
  endproperty
  a_ev1_clear: assert property (p_ev1_clear) else $error("event one not returned then cleared");

  property p_set_wins;
    (hit != 16'h0000) |=>
      (({ev1_ff, ev0_ff} & $past(hit & 16'hff7f)) == $past(hit & 16'hff7f));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost on detection");

  property p_edge_rise;
    $rose(src[`BIT_SIGNAL_ABSENCE]) && !EVENT_MASK_I[`BIT_SIGNAL_ABSENCE] |=> ev0_ff[`BIT_SIGNAL_ABSENCE];
  endproperty
  a_edge_rise: assert property (p_edge_rise) else $error("rising source not latched");

  property p_masked_quiet;
    s_read_ev1 ##0 (EVENT_MASK_I[15:8] == 8'hff) ##1 (EVENT_MASK_I[15:8] == 8'hff)[*2] |->
      ev1_ff == 8'h00;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("masked event latched");

  property p_irq;
    INT_REQ_O == (|{ev0_ff, ev1_ff});
  endproperty
  a_irq: assert property (p_irq) else $error("request disagrees with event bits");

  property p_transmit_clock_in_loss;
    $rose(transmit_clock_in_loss_ff) |-> (idle_cnt_ff == LOSS_LIMIT + 7'h01) && !$past(transmit_clock_in_toggled);
  endproperty
  a_transmit_clock_in_loss: assert property (p_transmit_clock_in_loss) else $error("clock loss not after 71 quiet cycles");

  property p_transmit_clock_in_clear;
    transmit_clock_in_toggled |=> !transmit_clock_in_loss_ff;
  endproperty
  a_transmit_clock_in_clear: assert property (p_transmit_clock_in_clear) else $error("clock loss held over a toggle");

  property p_cnt_bytes;
    HOST_RD_I && (HOST_ADDR_I == `OFS_ERROR_COUNT_HIGH_BYTE) |=> HOST_RDATA_O == $past(err_cnt_ff[15:8]);
  endproperty
  a_cnt_bytes: assert property (p_cnt_bytes) else $error("counter high byte wrong");

  property p_cnt_low;
    HOST_RD_I && (HOST_ADDR_I == `OFS_ERROR_COUNT_LOW_BYTE) |=> HOST_RDATA_O == $past(err_cnt_ff[7:0]);
  endproperty
  a_cnt_low: assert property (p_cnt_low) else $error("counter low byte wrong");

  property p_cnt_ovf;
    ERROR_COUNT_INC_I && cnt_full |=> (err_cnt_ff == 16'h0000) && cnt_ovf_ff;
  endproperty
  a_cnt_ovf: assert property (p_cnt_ovf) else $error("counter overflow not flagged");

  property p_reserved;
    s_read_ev0 |=> !HOST_RDATA_O[7] && !ev0_ff[7];
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved event bit not zero");

  sequence s_quiet_hits;
    (hit == 16'h0000) && (ev1_ff == 8'h00);
  endsequence

  property p_irq_drop;
    s_read_ev0 ##0 s_quiet_hits |=> !INT_REQ_O;
  endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("request kept after clearing read");

  property p_read_answer;
    HOST_RD_I |=> HOST_RVALID_O;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered next cycle");

  property p_no_stray_valid;
    !HOST_RD_I |=> !HOST_RVALID_O;
  endproperty
  a_no_stray_valid: assert property (p_no_stray_valid) else $error("valid shown without a read");

  property p_rdata_holds;
    !HOST_RD_I |=> $stable(HOST_RDATA_O);
  endproperty
  a_rdata_holds: assert property (p_rdata_holds) else $error("read data moved without a read");

  property p_unmapped;
    HOST_RD_I && ((HOST_ADDR_I < `OFS_LINE_STATUS_ONE) || (HOST_ADDR_I > `OFS_ERROR_COUNT_HIGH_BYTE)) |=>
      HOST_RDATA_O == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped address not zero");

  property p_loss_latch;
    $rose(transmit_clock_in_loss_ff) && !EVENT_MASK_I[`BIT_TX_CLOCK_LOSS] |=> ev0_ff[`BIT_TX_CLOCK_LOSS];
  endproperty
  a_loss_latch: assert property (p_loss_latch) else $error("clock loss not latched");

  property p_tick_latch;
    $rose(ONE_SECOND_TICK_I) && !EVENT_MASK_I[8+`BIT_ONE_SECOND_TICK] |=> ev1_ff[`BIT_ONE_SECOND_TICK];
  endproperty
  a_tick_latch: assert property (p_tick_latch) else $error("one-second tick not latched");

  property p_ovf_latch;
    cnt_ovf_ff && !EVENT_MASK_I[8+`BIT_COUNTER_OVERFLOW] |=> ev1_ff[`BIT_COUNTER_OVERFLOW];
  endproperty
  a_ovf_latch: assert property (p_ovf_latch) else $error("counter overflow not latched");

  property p_any_change;
    $fell(src[`BIT_SIGNAL_ABSENCE]) && !EVENT_MASK_I[`BIT_SIGNAL_ABSENCE] &&
      EVENT_EDGE_SELECT_I[`BIT_SIGNAL_ABSENCE] |=> ev0_ff[`BIT_SIGNAL_ABSENCE];
  endproperty
  a_any_change: assert property (p_any_change) else $error("falling source not latched on any change");

  property p_fall_ignored;
    $fell(src[`BIT_SIGNAL_ABSENCE]) && !EVENT_EDGE_SELECT_I[`BIT_SIGNAL_ABSENCE] &&
      !ev0_ff[`BIT_SIGNAL_ABSENCE] |=> !ev0_ff[`BIT_SIGNAL_ABSENCE];
  endproperty
  a_fall_ignored: assert property (p_fall_ignored) else $error("falling source latched on rise select");

  property p_mask_blocks;
    EVENT_MASK_I[`BIT_SIGNAL_ABSENCE] && !ev0_ff[`BIT_SIGNAL_ABSENCE] |=> !ev0_ff[`BIT_SIGNAL_ABSENCE];
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) else $error("masked source latched");

  property p_cnt_inc;
    ERROR_COUNT_INC_I && !cnt_full |=> err_cnt_ff == $past(err_cnt_ff) + 16'h0001;
  endproperty
  a_cnt_inc: assert property (p_cnt_inc) else $error("counter did not step");

  property p_cnt_hold;
    !ERROR_COUNT_INC_I |=> $stable(err_cnt_ff);
  endproperty
  a_cnt_hold: assert property (p_cnt_hold) else $error("counter moved without increment");

endmodule

// ---- tb_top.sv ----
// testbench for the line status, event and error counter register bank
`timescale 1ns/100ps
module tb_top;
  import line_status_pkg::*;
  logic        clk, rstn, rlb, tick, inc, txc, tx_run, rd, rvalid, irq;
  logic [6:0]  ev0;
  logic [7:2]  ev1;
  logic [15:0] msk, esel;
  logic [7:0]  addr, rdata, d;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          cyc = 0;

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  host_model host_model_i (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid), .addr_o(addr), .rd_o(rd));

  line_status_regs line_status_regs_i (
    .SYS_CLK_I(clk), .RSTN_I(rstn), .HOST_ADDR_I(addr), .HOST_RD_I(rd), .HOST_RDATA_O(rdata),
    .HOST_RVALID_O(rvalid), .INT_REQ_O(irq), .REMOTE_LOOPBACK_CLOSED_I(rlb),
    .LOOP_ACTIVATE_STAT_I(ev0[6]), .LOOP_DEACTIVATE_STAT_I(ev0[5]), .PATTERN_SYNC_STAT_I(ev0[4]),
    .TRANSMIT_CLOCK_IN_I(txc), .DRIVER_FAULT_STAT_I(ev0[2]), .ALARM_INDICATION_STAT_I(ev0[1]),
    .SIGNAL_ABSENCE_STAT_I(ev0[0]), .WAVEFORM_OVERFLOW_I(ev1[7]), .JITTER_OVERFLOW_I(ev1[6]),
    .JITTER_UNDERFLOW_I(ev1[5]), .PATTERN_BIT_ERROR_I(ev1[4]), .EXCESS_ZEROS_I(ev1[3]),
    .CODE_VIOLATION_I(ev1[2]), .ONE_SECOND_TICK_I(tick), .ERROR_COUNT_INC_I(inc),
    .EVENT_MASK_I(msk), .EVENT_EDGE_SELECT_I(esel));

  // free-running transmit clock unless a test stops it
  always @(negedge clk) begin
    if (tx_run)
      txc <= ~txc;
  end

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    host_model_i.read_reg(a, d);
    check($sformatf("reg %h", a), d, exp);
  endtask

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // the whole run needs about 66k cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_mismatch++;
      wrap_up;
    end
  end

  initial begin
    rstn = 1'b0;
    rlb = 1'b0;
    tick = 1'b0;
    inc = 1'b0;
    txc = 1'b0;
    tx_run = 1'b1;
    ev0 = '0;
    ev1 = '0;
    msk = '0;
    esel = '0;
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    for (int a = 8'h18; a <= 8'h1d; a++)
      rd_chk(a[7:0], 8'h00);
    check("irq", {7'h00, irq}, 8'h00);
    $display("test reset values done");
    rlb = 1'b1;
    repeat (4) @(negedge clk);
    rd_chk(8'h18, 8'h20);
    rlb = 1'b0;
    repeat (4) @(negedge clk);
    rd_chk(8'h18, 8'h00);
    $display("test loopback status done");
    for (int i = 0; i < 7; i++) begin
      if (i == 3)
        continue;
      ev0[i] = 1'b1;
      repeat (5) @(negedge clk);
      check("irq", {7'h00, irq}, 8'h01);
      rd_chk(8'h19, 8'h01 << i);
      rd_chk(8'h19, 8'h00);
      check("irq", {7'h00, irq}, 8'h00);
      ev0[i] = 1'b0;
      repeat (5) @(negedge clk);
      rd_chk(8'h19, 8'h00);
    end
    msk[0] = 1'b1;
    ev0[0] = 1'b1;
    repeat (5) @(negedge clk);
    rd_chk(8'h19, 8'h00);
    msk[0] = 1'b0;
    esel[0] = 1'b1;
    ev0[0] = 1'b0;
    repeat (5) @(negedge clk);
    rd_chk(8'h19, 8'h01);
    esel[0] = 1'b0;
    $display("test first event latch done");
    for (int i = 2; i < 8; i++) begin
      ev1[i] = 1'b1;
      repeat (4) @(negedge clk);
      ev1[i] = 1'b0;
      repeat (4) @(negedge clk);
      rd_chk(8'h1a, 8'h01 << i);
      rd_chk(8'h1a, 8'h00);
    end
    tick = 1'b1;
    @(negedge clk);
    tick = 1'b0;
    repeat (3) @(negedge clk);
    rd_chk(8'h1a, 8'h02);
    msk[15:8] = 8'hff;
    ev1[5] = 1'b1;
    tick = 1'b1;
    @(negedge clk);
    tick = 1'b0;
    repeat (4) @(negedge clk);
    ev1[5] = 1'b0;
    check("irq", {7'h00, irq}, 8'h00);
    rd_chk(8'h1a, 8'h00);
    repeat (4) @(negedge clk);
    msk[15:8] = 8'h00;
    $display("test second event latch done");
    tx_run = 1'b0;
    repeat (60) @(negedge clk);
    rd_chk(8'h19, 8'h00);
    repeat (20) @(negedge clk);
    rd_chk(8'h19, 8'h08);
    tx_run = 1'b1;
    repeat (10) @(negedge clk);
    rd_chk(8'h19, 8'h00);
    $display("test transmit clock loss done");
    inc = 1'b1;
    repeat (300) @(negedge clk);
    inc = 1'b0;
    rd_chk(8'h1b, 8'h2c);
    rd_chk(8'h1c, 8'h01);
    inc = 1'b1;
    repeat (65236) @(negedge clk);
    inc = 1'b0;
    repeat (3) @(negedge clk);
    check("irq", {7'h00, irq}, 8'h01);
    rd_chk(8'h1a, 8'h01);
    rd_chk(8'h1b, 8'h00);
    rd_chk(8'h1c, 8'h00);
    $display("test error counter done");
    ev0[1] = 1'b1;
    repeat (5) @(negedge clk);
    check("irq", {7'h00, irq}, 8'h01);
    rstn = 1'b0;
    ev0[1] = 1'b0;
    repeat (2) @(negedge clk);
    check("irq", {7'h00, irq}, 8'h00);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    rd_chk(8'h19, 8'h00);
    rd_chk(8'h1a, 8'h00);
    $display("test reset in mid-run done");
    wrap_up;
  end
endmodule
